/* common/hpc_cfg.svh */
`ifndef HPC_CFG_SVH
`define HPC_CFG_SVH

// Byte offsets in the configuration image.
`define HPC_OFS_OPTIONS_TWO   8'h07
`define HPC_OFS_FIXED_MASK    8'h08
`define HPC_OFS_SP_PORT_OFF   8'h09
`define HPC_OFS_BP_PORT_OFF   8'h0a
`define HPC_OFS_SP_MAX_DRAW   8'h0b

// Reset values.
`define HPC_RST_OPTIONS_TWO   8'h90
`define HPC_RST_FIXED_MASK    8'h00
`define HPC_RST_SP_PORT_OFF   8'h00
`define HPC_RST_BP_PORT_OFF   8'h00
`define HPC_RST_SP_MAX_DRAW   8'h01

// Field positions in the options byte.
`define HPC_BIT_AUTO_SWITCH   7
`define HPC_BIT_OC_DLY_HI     5
`define HPC_BIT_OC_DLY_LO     4
`define HPC_BIT_COMPOUND      3

// Port bits 3..1 of the mask bytes map to downstream ports 3..1.
`define HPC_PORT_FIRST        1
`define HPC_PORTS             3

// Overcurrent delays in microseconds and the core clock rate in MHz.
`define HPC_CLK_MHZ           20
`define HPC_OC_DLY0_US        100
`define HPC_OC_DLY1_US        2000
`define HPC_OC_DLY2_US        4000
`define HPC_OC_DLY3_US        6000
`define HPC_OC_DLY0_CYC       (`HPC_OC_DLY0_US * `HPC_CLK_MHZ)
`define HPC_OC_DLY1_CYC       (`HPC_OC_DLY1_US * `HPC_CLK_MHZ)
`define HPC_OC_DLY2_CYC       (`HPC_OC_DLY2_US * `HPC_CLK_MHZ)
`define HPC_OC_DLY3_CYC       (`HPC_OC_DLY3_US * `HPC_CLK_MHZ)

// Draw count is in 2 mA steps, so 50 counts is 100 mA.
`define HPC_DRAW_STEP_MA      2
`define HPC_OC_CNT_W          17

`endif

/* common/hpc_pkg.sv */
`default_nettype none
package hpc_pkg;

  typedef enum logic [0:0] {
    HPC_BUS  = 1'b0,
    HPC_SELF = 1'b1
  } hpc_pwr_t;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } hpc_cfg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } hpc_cfg_rsp_t;

  typedef struct packed {
    logic [7:0]  options_two;
    logic [7:0]  fixed_mask;
    logic [7:0]  sp_off;
    logic [7:0]  bp_off;
    logic [7:0]  sp_draw;
    hpc_pwr_t    mode;
    logic [16:0] oc_cnt;
    logic        oc_flag;
    hpc_cfg_rsp_t rsp;
    logic [2:0]  port_off;
    logic [2:0]  port_fixed;
    logic        compound;
    logic        self_powered;
    logic [8:0]  draw_ma;
  } hpc_state_t;

endpackage
`default_nettype wire

/* rtl/hpc_power_config.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hpc_cfg.svh"

// Function
// RULE1 - Auto switch bit lets hub fall to bus power
// RULE2 - Auto switch returns to self power on supply
// RULE3 - Delay field selects 0.1, 2, 4, 6 ms
// RULE4 - Options bit 3 flags compound device membership
// RULE5 - Options bit 6 and bits 2:0 unused
// RULE6 - Fixed mask bits 3..1 mark non-removable ports
// RULE7 - Configurer keeps fixed mask bits 7:4, 0 zero
// RULE8 - Self-powered mask disables ports while self powered
// RULE9 - Bus-powered mask disables ports while bus powered
// RULE10 - Configurer sets contiguous ports, bit 0 zero
// RULE11 - Report self-powered upstream draw in 2 mA steps
// RULE12 - Configurer includes zero-current peripheral draw
// RULE13 - Count of 50 represents 100 mA
// RULE14 - Configurer keeps self draw at most 100 mA
// RULE15 - Auto switching ignores source select, uses detect
// RULE16 - Fixed mask applied only for compound device
// RULE17 - Overcurrent reported after sense held full delay
// RULE18 - Active disable mask follows current power mode
module hpc_power_config #(
  parameter int unsigned OC_DLY0_CYC = `HPC_OC_DLY0_CYC,
  parameter int unsigned OC_DLY1_CYC = `HPC_OC_DLY1_CYC,
  parameter int unsigned OC_DLY2_CYC = `HPC_OC_DLY2_CYC,
  parameter int unsigned OC_DLY3_CYC = `HPC_OC_DLY3_CYC
) (
  input  wire logic                  clk,                 // Core clock, 20 MHz.
  input  wire logic                  rst,                 // Asynchronous reset, active high.
  input  wire hpc_pkg::hpc_cfg_req_t cfg_req,             // Byte write/read from the config loader.
  output var  hpc_pkg::hpc_cfg_rsp_t cfg_rsp,             // Read answer, valid one cycle.
  input  wire logic                  local_supply_detect, // Local supply present.
  input  wire logic                  power_source_select, // Static self/bus choice, 1 = self.
  input  wire logic                  overcurrent_sense,   // Raw overcurrent sense, active high.
  output logic                       self_powered,        // Current power mode, 1 = self.
  output logic [2:0]                 port_off,            // Ports 3..1 permanently disabled.
  output logic [2:0]                 port_fixed,          // Ports 3..1 non-removable.
  output logic                       compound_device,     // Hub is part of a compound device.
  output logic                       overcurrent_flag,    // Qualified overcurrent.
  output logic [7:0]                 self_power_upstream_draw, // Self-powered draw count.
  output logic [8:0]                 upstream_draw_ma     // Same draw in mA.
);
  import hpc_pkg::*;

  hpc_state_t st;
  hpc_state_t next_st;
  logic [2:0] off_sp;
  logic [2:0] off_bp;
  logic [2:0] fixed_c;

  // Per-port slices of the mask bytes.
  for (genvar p = 0; p < `HPC_PORTS; p++) begin : g_port
    assign off_sp[p]  = st.sp_off[p + `HPC_PORT_FIRST];     // RULE8
    assign off_bp[p]  = st.bp_off[p + `HPC_PORT_FIRST];     // RULE9
    assign fixed_c[p] = st.fixed_mask[p + `HPC_PORT_FIRST]; // RULE6
  end

  function automatic logic [16:0] oc_target(input logic [1:0] sel);
    case (sel)
      2'h0:    oc_target = 17'(OC_DLY0_CYC); // RULE3
      2'h1:    oc_target = 17'(OC_DLY1_CYC);
      2'h2:    oc_target = 17'(OC_DLY2_CYC);
      2'h3:    oc_target = 17'(OC_DLY3_CYC);
      default: oc_target = 17'(OC_DLY1_CYC);
    endcase
  endfunction

  always_comb begin
    logic       auto_sw;
    logic [1:0] overcurrent_delay_select;
    logic [16:0] target;
    auto_sw                  = 1'b0;
    overcurrent_delay_select = 2'h0;
    target                   = 17'h0;
    next_st                  = st;

    // Bytes are written whole; reserved bits are kept but drive nothing.
    if (cfg_req.wr) begin
      case (cfg_req.addr)
        `HPC_OFS_OPTIONS_TWO: next_st.options_two = cfg_req.data; // RULE5
        `HPC_OFS_FIXED_MASK:  next_st.fixed_mask  = cfg_req.data;
        `HPC_OFS_SP_PORT_OFF: next_st.sp_off      = cfg_req.data;
        `HPC_OFS_BP_PORT_OFF: next_st.bp_off      = cfg_req.data;
        `HPC_OFS_SP_MAX_DRAW: next_st.sp_draw     = cfg_req.data;
        default: ;
      endcase
    end

    // Other offsets belong to neighbouring logic, so they read as zero here.
    next_st.rsp.valid = cfg_req.rd;
    if (cfg_req.rd) begin
      case (cfg_req.addr)
        `HPC_OFS_OPTIONS_TWO: next_st.rsp.data = st.options_two;
        `HPC_OFS_FIXED_MASK:  next_st.rsp.data = st.fixed_mask;
        `HPC_OFS_SP_PORT_OFF: next_st.rsp.data = st.sp_off;
        `HPC_OFS_BP_PORT_OFF: next_st.rsp.data = st.bp_off;
        `HPC_OFS_SP_MAX_DRAW: next_st.rsp.data = st.sp_draw;
        default:              next_st.rsp.data = 8'h00;
      endcase
    end

    // Power mode: the supply detect decides while auto switching is on.
    auto_sw = st.options_two[`HPC_BIT_AUTO_SWITCH];
    if (auto_sw) begin
      case (st.mode)
        HPC_SELF: if (!local_supply_detect) next_st.mode = HPC_BUS;  // RULE1
        HPC_BUS:  if (local_supply_detect)  next_st.mode = HPC_SELF; // RULE2 RULE15
        default:  next_st.mode = HPC_BUS;
      endcase
    end else begin
      next_st.mode = power_source_select ? HPC_SELF : HPC_BUS; // RULE1
    end

    // Mask outputs follow the mode in force this cycle.
    next_st.self_powered = (st.mode == HPC_SELF);
    next_st.port_off     = (st.mode == HPC_SELF) ? off_sp : off_bp; // RULE18 RULE8 RULE9
    next_st.compound     = st.options_two[`HPC_BIT_COMPOUND];       // RULE4
    next_st.port_fixed   = st.options_two[`HPC_BIT_COMPOUND] ? fixed_c : 3'h0; // RULE16 RULE6

    // Draw reported as a count and scaled by the step size.
    // Scaled from the byte being stored, so the count and mA outputs move together.
    next_st.draw_ma = 9'({1'b0, next_st.sp_draw} * `HPC_DRAW_STEP_MA); // RULE11 RULE13

    // Sense must stay high for the whole selected delay; any drop restarts it.
    overcurrent_delay_select = st.options_two[`HPC_BIT_OC_DLY_HI:`HPC_BIT_OC_DLY_LO];
    target                   = oc_target(overcurrent_delay_select);
    if (!overcurrent_sense) begin
      next_st.oc_cnt  = 17'h0;
      next_st.oc_flag = 1'b0;
    end else if (st.oc_cnt + 17'h1 >= target) begin
      next_st.oc_cnt  = target;
      next_st.oc_flag = 1'b1; // RULE17
    end else begin
      next_st.oc_cnt  = st.oc_cnt + 17'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st              <= '0;
      st.options_two  <= `HPC_RST_OPTIONS_TWO;
      st.fixed_mask   <= `HPC_RST_FIXED_MASK;
      st.sp_off       <= `HPC_RST_SP_PORT_OFF;
      st.bp_off       <= `HPC_RST_BP_PORT_OFF;
      st.sp_draw      <= `HPC_RST_SP_MAX_DRAW;
      st.mode         <= HPC_BUS;
      st.draw_ma      <= 9'(`HPC_RST_SP_MAX_DRAW * `HPC_DRAW_STEP_MA);
    end else begin
      st <= next_st;
    end
  end

  assign cfg_rsp                  = st.rsp;
  assign self_powered             = st.self_powered;
  assign port_off                 = st.port_off;
  assign port_fixed               = st.port_fixed;
  assign compound_device          = st.compound;
  assign overcurrent_flag         = st.oc_flag;
  assign self_power_upstream_draw = st.sp_draw; // RULE11
  assign upstream_draw_ma         = st.draw_ma;

endmodule
`default_nettype wire

/* tb/hpc_cfg_loader.sv */
`timescale 1ns/1ps
`default_nettype none
module hpc_cfg_loader (
  input  wire logic                  clk,     // Core clock.
  output var  hpc_pkg::hpc_cfg_req_t cfg_req, // Request.
  input  wire hpc_pkg::hpc_cfg_rsp_t cfg_rsp  // Answer.
);
  import hpc_pkg::*;
  initial cfg_req = '0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(negedge clk);
    cfg_req = '{w, !w, a, (a inside {8'h08, 8'h09, 8'h0a}) ? d & 8'h0e : d};
    @(negedge clk);
    // The answer stands for one cycle after the request edge, so take it here.
    q = cfg_rsp.valid ? cfg_rsp.data : 8'hxx;
    // Released lines carry the inverse, so a stale byte cannot pass for a live one.
    cfg_req = '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule
`default_nettype wire

/* tb/hpc_power_config_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module hpc_power_config_monitor (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire hpc_pkg::hpc_cfg_req_t cfg_req,
  input wire hpc_pkg::hpc_cfg_rsp_t cfg_rsp,
  input wire logic                  local_supply_detect,
  input wire logic                  power_source_select,
  input wire logic                  overcurrent_sense,
  input wire logic                  self_powered,
  input wire logic [2:0]            port_off,
  input wire logic [2:0]            port_fixed,
  input wire logic                  compound_device,
  input wire logic                  overcurrent_flag,
  input wire logic [7:0]            self_power_upstream_draw,
  input wire logic [8:0]            upstream_draw_ma
);
  import hpc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_rd; cfg_req.rd |=> cfg_rsp.valid; endproperty
  a_rd: assert property (p_rd) else $error("read answer missing");
  property p_ma; upstream_draw_ma == {self_power_upstream_draw, 1'b0}; endproperty
  a_ma: assert property (p_ma) else $error("draw scale wrong");
  property p_fix; !compound_device |-> port_fixed == 3'h0; endproperty
  a_fix: assert property (p_fix) else $error("fixed ports outside compound");
  property p_off; $changed(port_off) |-> $past(cfg_req.wr, 2) || $changed(self_powered); endproperty
  a_off: assert property (p_off) else $error("port_off moved alone");
  property p_mode;
    $changed(self_powered) |-> self_powered == $past(local_supply_detect, 2)
      || self_powered == $past(power_source_select, 2);
  endproperty
  a_mode: assert property (p_mode) else $error("mode without cause");
  property p_cmp; $changed(compound_device) |-> $past(cfg_req.wr, 2) && $past(cfg_req.addr, 2) == 8'h07; endproperty
  a_cmp: assert property (p_cmp) else $error("compound moved alone");
  property p_ocr; $rose(overcurrent_flag) |-> $past(overcurrent_sense, 4); endproperty
  a_ocr: assert property (p_ocr) else $error("overcurrent too early");
  property p_occ; !overcurrent_sense |=> !overcurrent_flag; endproperty
  a_occ: assert property (p_occ) else $error("overcurrent held");
  c_oc: cover property ($rose(overcurrent_flag));
  c_sp: cover property ($rose(self_powered));
  c_fx: cover property (port_fixed != 3'h0);
endmodule
bind hpc_power_config hpc_power_config_monitor hpc_power_config_monitor_inst (.*);
`default_nettype wire

/* tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import hpc_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  logic         local_supply_detect = 1'b0;
  logic         power_source_select = 1'b0;
  logic         overcurrent_sense = 1'b0;
  hpc_cfg_req_t cfg_req;
  hpc_cfg_rsp_t cfg_rsp;
  logic         self_powered, compound_device, overcurrent_flag, auto, sp;
  logic [2:0]   port_off, port_fixed;
  logic [7:0]   self_power_upstream_draw, q, d;
  logic [8:0]   upstream_draw_ma;
  logic [31:0]  seed = 32'h49b5;
  int           bad_count = 0, checked = 0, n;
  always #25 clk = ~clk;
  hpc_power_config #(.OC_DLY0_CYC(4), .OC_DLY1_CYC(8), .OC_DLY2_CYC(12), .OC_DLY3_CYC(16)) hpc_power_config_inst (.*);
  hpc_cfg_loader hpc_cfg_loader_inst (.*);
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic int oc_cyc(input int k);
    return 4 * (k + 1);
  endfunction
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask
  task automatic check(input logic [8:0] got, input logic [8:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xf(input logic w, input logic [7:0] a, input logic [7:0] v);
    hpc_cfg_loader_inst.xfer(w, a, v, q);
    tick(1);
  endtask
  task automatic wrap_up();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    bad_count++;
    wrap_up();
  end
  initial begin
    tick(5);
    rst = 1'b0;
    for (int a = 6; a < 13; a++) begin
      xf(1'b0, 8'(a), 8'h00);
      check(9'(q), (a == 7) ? 9'h090 : (a == 11) ? 9'h001 : 9'h000);
    end
    check(upstream_draw_ma, 9'h002);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      d = (i < 2) ? 8'(50 * i) : 8'(rnd() % 51);
      xf(1'b1, 8'h0b, d);
      check(upstream_draw_ma, 9'(d) << 1);
      d = (rnd() & 8'h47) | 8'h90;
      xf(1'b1, 8'h07, d);
      xf(1'b0, 8'h07, 8'h00);
      check(9'(q), 9'(d));
      check(9'(compound_device), 9'h000);
    end
    $display("test draw done");
    xf(1'b1, 8'h09, 8'h02);
    xf(1'b1, 8'h0a, 8'h0c);
    for (int i = 0; i < 9; i++) begin
      {auto, local_supply_detect, power_source_select} = (i == 8) ? 3'h4 : 3'(i);
      xf(1'b1, 8'h07, {auto, 7'h10});
      tick(3);
      sp = auto ? local_supply_detect : power_source_select;
      check(9'(self_powered), 9'(sp));
      check(9'(port_off), sp ? 9'h001 : 9'h006);
    end
    $display("test power done");
    xf(1'b1, 8'h08, 8'h0a);
    for (int c = 0; c < 2; c++) begin
      xf(1'b1, 8'h07, (c == 1) ? 8'h98 : 8'h90);
      check(9'({compound_device, port_fixed}), (c == 1) ? 9'h00d : 9'h000);
    end
    $display("test compound done");
    for (int k = 0; k < 4; k++) begin
      xf(1'b1, 8'h07, {2'h2, 2'(k), 4'h0});
      overcurrent_sense = 1'b1;
      tick(oc_cyc(k) - 1);
      check(9'(overcurrent_flag), 9'h000);
      overcurrent_sense = 1'b0;
      tick(1);
      overcurrent_sense = 1'b1;
      n = 0;
      while (overcurrent_flag !== 1'b1 && n < 40) begin
        tick(1);
        n++;
      end
      check(9'(n), 9'(oc_cyc(k)));
      overcurrent_sense = 1'b0;
      tick(2);
      check(9'(overcurrent_flag), 9'h000);
    end
    $display("test overcurrent done");
    wrap_up();
  end
endmodule
`default_nettype wire
